// ### rtl/sdf_pkg.sv
// constants shared by the switch diagnosis flag logic
// assumes one system clock; all pins are sampled and synchronised first
// Overview of operation
// - five-bit hardware_configuration: read lho,cfg3,bypass,pwm,ctl; write reset,cfg3,0,pwm,ctl
// - writing clear_thermal_latch as 1 clears all thermal latches; 0 keeps them
// - each channel_error_flag is over-temperature flag OR latched overload flag
// - overload stays latched until diagnosis sent; cleared between second and third SCLK rise
// - over-temperature latches channel off; only clear command releases it
// - after clear command, temperature error wiped next frame; relatches after third rise
// - first diagnosis after clear command still shows the old temperature error
// - persisting overload keeps the error flag set through its clear, as new events win in that cycle
// - sense output carries only the channel chosen by sense_select
// - sense_select codes 5 to 7 each disable the sense output completely
// - over-current or over-temperature switches that channel's sense signal off
// - sense delivered only in fault-free ON state, high impedance otherwise
// - error flag set only by ON-state limitation, short to ground, over-temperature
// - bypass monitor looks only at the channel chosen by sense_select
// - bypass monitor result readable in hardware_configuration bit 2
// - bypass monitor updates in both ON and OFF state
// - led_mode_bit in watchdog_led_register picks sense ratio for channels 0 to 2
package sdf_pkg;
	localparam int NCH = 5;
	localparam int NLED = 3;
	localparam int FB = 8;
	localparam int SEL_W = 3;
	localparam int CMD_WR = 7;
	localparam int CMD_A_HI = 6;
	localparam int CMD_A_LO = 5;
	localparam int CMD_RD_REG = 4;
	localparam logic [1:0] ADDR_HARDWARE_CONFIGURATION = 2'h0;
	localparam logic [1:0] ADDR_DCR = 2'h1;
	localparam logic [1:0] ADDR_WATCHDOG_LED_REGISTER = 2'h2;
	localparam logic [1:0] ADDR_OUT = 2'h3;
	localparam int HW_CTL = 0;
	localparam int HW_PWM = 1;
	localparam int HW_SBM = 2;
	localparam int HW_CFG3 = 3;
	localparam int HW_RST = 4;
	localparam logic [SEL_W-1:0] SEL_OFF = 3'h7;
	localparam logic [SEL_W-1:0] DCR_RST = 3'h7;
	localparam logic [NLED-1:0] WATCHDOG_LED_REGISTER_RST = 3'h0;
	localparam logic [NCH-1:0] OUT_RST = 5'h00;
	localparam logic [3:0] EDGE_CLR = 4'h1;
	localparam logic [3:0] EDGE_HOLD = 4'h2;
	localparam logic [3:0] EDGE_FRAME = 4'h8;
endpackage

// ### rtl/sdf_sync.sv
// two-stage synchroniser for pin-level inputs
// assumes inputs are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module sdf_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	import sdf_pkg::*;
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sdf_sync_t;
	sdf_sync_t q, n;
	always_comb
	begin
		n.s1 = d_i;
		n.s2 = q.s1;
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else
			q <= n;
	end
	assign q_o = q.s2;
endmodule
`default_nettype wire

// ### rtl/sdf_frame.sv
// spi frame tracker: sclk edges and chip-select boundaries
// assumes synchronised cs and sclk; sclk is oversampled by sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module sdf_frame (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	output logic rise_o,
	output logic fall_o,
	output logic start_o,
	output logic end_o,
	output logic [3:0] edges_o
);
	import sdf_pkg::*;
	typedef struct packed {
		logic sclk_d;
		logic cs_n_d;
		logic armed;
		logic [3:0] edges;
	} sdf_frame_t;
	sdf_frame_t q, n;
	always_comb
	begin
		n = q;
		n.sclk_d = sclk_i;
		n.cs_n_d = cs_n_i;
		// synchroniser resets to 0: wait for an idle select before framing
		n.armed = q.armed | cs_n_i;
		// saturate so an over-long frame never wraps to a legal count
		if (start_o)
			n.edges = 4'h0;
		else if (rise_o && q.edges != 4'hf)
			n.edges = q.edges + 4'h1;
	end
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '{sclk_d: 1'b0, cs_n_d: 1'b1, armed: 1'b0, edges: 4'h0};
		else
			q <= n;
	end
	assign rise_o = sclk_i & ~q.sclk_d & ~cs_n_i;
	assign fall_o = ~sclk_i & q.sclk_d & ~cs_n_i;
	assign start_o = q.armed & q.cs_n_d & ~cs_n_i;
	assign end_o = q.armed & ~q.cs_n_d & cs_n_i;
	assign edges_o = q.edges;
endmodule
`default_nettype wire

// ### rtl/sdf_core.sv
// diagnosis flags, thermal latches, sense routing and spi registers
// assumes 8-bit spi frames, mode 0, sclk well below sys_clk_i / 4
`timescale 1ns/1ps
`default_nettype none
module sdf_core (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_si_i,
	input wire logic limp_home_i,
	input wire logic [sdf_pkg::NCH-1:0] over_temp_i,
	input wire logic [sdf_pkg::NCH-1:0] overload_i,
	input wire logic [sdf_pkg::NCH-1:0] bypass_cmp_i,
	output logic spi_so_o,
	output logic spi_so_oe_o,
	output logic [sdf_pkg::NCH-1:0] gate_on_o,
	output logic [sdf_pkg::NCH-1:0] sense_route_o,
	output logic sense_oe_o,
	output logic [sdf_pkg::NLED-1:0] led_mode_o
);
	import sdf_pkg::*;
	localparam int SW = 4 + 3 * NCH;

	typedef struct packed {
		logic cfg3;
		logic pwm;
		logic [SEL_W-1:0] sel;
		logic [NLED-1:0] led;
		logic [NCH-1:0] on;
		logic [NCH-1:0] therm;
		logic [NCH-1:0] temp_err;
		logic [NCH-1:0] ovl;
		logic ctl_pend;
		logic ctl_frame;
		logic diag_frame;
		logic rd_req;
		logic [1:0] rd_addr;
		logic [FB-1:0] sh_in;
		logic [FB-1:0] sh_out;
		logic so;
		logic so_oe;
		logic [NCH-1:0] gate;
		logic [NCH-1:0] sense;
		logic sense_oe;
		logic bypass_monitor_result;
	} sdf_core_t;

	sdf_core_t q, n;
	logic [SW-1:0] raw, syn;
	logic cs_n, sclk, si, limp_home_state;
	logic [NCH-1:0] ot, ol, byp, sense_ok;
	logic rise, fall, start, fin;
	logic [3:0] edges;
	logic [FB-1:0] diag_word, rd_word, cmd;
	logic ctl_clr, ovl_clr, wipe;

	assign raw = {bypass_cmp_i, overload_i, over_temp_i, limp_home_i,
		spi_si_i, spi_sclk_i, spi_cs_n_i};

	sdf_sync #(.W(SW)) u_sync (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.d_i(raw),
		.q_o(syn)
	);

	assign cs_n = syn[0];
	assign sclk = syn[1];
	assign si = syn[2];
	assign limp_home_state = syn[3];
	assign ot = syn[4 +: NCH];
	assign ol = syn[4 + NCH +: NCH];
	assign byp = syn[4 + 2 * NCH +: NCH];

	sdf_frame u_frame (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.cs_n_i(cs_n),
		.sclk_i(sclk),
		.rise_o(rise),
		.fall_o(fall),
		.start_o(start),
		.end_o(fin),
		.edges_o(edges)
	);

	// sense current only for the selected, healthy, driven channel
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_sense
			assign sense_ok[gi] = (q.sel == SEL_W'(gi))
				& q.gate[gi] & ~ol[gi] & ~ot[gi];
		end
	endgenerate

	// error word captured before any clear in the same frame
	assign diag_word = {(FB - NCH)'(0), q.temp_err | q.ovl};

	always_comb
	begin
		rd_word = '0;
		case (q.rd_addr)
			ADDR_HARDWARE_CONFIGURATION:
				rd_word = {3'h0, limp_home_state, q.cfg3, q.bypass_monitor_result, q.pwm, q.ctl_pend};
			ADDR_DCR:
				rd_word = {(FB - SEL_W)'(0), q.sel};
			ADDR_WATCHDOG_LED_REGISTER:
				rd_word = {(FB - NLED)'(0), q.led};
			ADDR_OUT:
				rd_word = {(FB - NCH)'(0), q.on};
			default:
				rd_word = '0;
		endcase
	end

	assign cmd = q.sh_in;

	always_comb
	begin
		n = q;
		ctl_clr = 1'b0;
		n.so_oe = ~cs_n;
		if (start)
		begin
			n.sh_out = q.rd_req ? rd_word : diag_word;
			n.so = q.rd_req ? rd_word[FB-1] : diag_word[FB-1];
			n.diag_frame = ~q.rd_req;
			n.ctl_frame = q.ctl_pend;
			n.ctl_pend = 1'b0;
			n.sh_in = '0;
		end
		if (fall)
		begin
			n.sh_out = {q.sh_out[FB-2:0], 1'b0};
			n.so = q.sh_out[FB-2];
		end
		if (rise)
			n.sh_in = {q.sh_in[FB-2:0], si};
		if (fin)
		begin
			n.diag_frame = 1'b0;
			n.ctl_frame = 1'b0;
			// short or long frames are dropped whole
			if (edges == EDGE_FRAME)
			begin
				if (cmd[CMD_WR])
				begin
					n.rd_req = 1'b0;
					case (cmd[CMD_A_HI:CMD_A_LO])
						ADDR_HARDWARE_CONFIGURATION:
						begin
							if (cmd[HW_RST])
							begin
								n.cfg3 = 1'b0;
								n.pwm = 1'b0;
								n.sel = DCR_RST;
								n.led = WATCHDOG_LED_REGISTER_RST;
								n.on = OUT_RST;
							end
							else
							begin
								n.cfg3 = cmd[HW_CFG3];
								n.pwm = cmd[HW_PWM];
								ctl_clr = cmd[HW_CTL];
								n.ctl_pend = cmd[HW_CTL];
							end
						end
						ADDR_DCR:
							n.sel = cmd[SEL_W-1:0];
						ADDR_WATCHDOG_LED_REGISTER:
							n.led = cmd[NLED-1:0];
						ADDR_OUT:
							n.on = cmd[NCH-1:0];
						default:
							n.rd_req = 1'b0;
					endcase
				end
				else
				begin
					n.rd_req = cmd[CMD_RD_REG];
					n.rd_addr = cmd[CMD_A_HI:CMD_A_LO];
				end
			end
		end
		// new therm and ovl events win over their clear in the same cycle; the wipe wins over new temp_err events
		n.therm = (q.therm & ~{NCH{ctl_clr}}) | ot;
		n.ovl = (q.ovl & ~{NCH{ovl_clr}}) | (ol & q.on);
		n.temp_err = wipe ? '0 : (q.temp_err | (ot & q.on));
		n.gate = n.on & ~n.therm;
		n.sense = sense_ok;
		// own flop, so the pin enable never glitches on a decode
		n.sense_oe = |sense_ok;
		// monitor runs whatever the channel state, off code reads 0
		n.bypass_monitor_result = (q.sel < SEL_W'(NCH)) ? byp[q.sel] : 1'b0;
	end

	assign ovl_clr = q.diag_frame & rise & (edges == EDGE_CLR);
	// temperature error held at zero until the third rise passes
	assign wipe = q.ctl_frame & ((edges == EDGE_HOLD)
		| (rise & (edges == EDGE_CLR)));

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			q <= '0;
			q.sel <= DCR_RST;
			q.led <= WATCHDOG_LED_REGISTER_RST;
			q.on <= OUT_RST;
		end
		else
			q <= n;
	end

	assign spi_so_o = q.so;
	assign spi_so_oe_o = q.so_oe;
	assign gate_on_o = q.gate;
	assign sense_route_o = q.sense;
	assign sense_oe_o = q.sense_oe;
	assign led_mode_o = q.led;

	a_diag_word_or: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(start && !q.rd_req) |=>
		q.sh_out[NCH-1:0] == ($past(q.temp_err) | $past(q.ovl)))
		else $error("diagnosis word is not the or of the flags");

	a_ovl_clear: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(q.diag_frame && rise && edges == EDGE_CLR && !(|(ol & q.on)))
		|=> q.ovl == '0)
		else $error("overload flags not cleared at second rise");

	a_ovl_hold: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!q.diag_frame |=> (q.ovl & $past(q.ovl)) == $past(q.ovl))
		else $error("overload flag dropped outside a diagnosis frame");

	a_ovl_reset: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(|(ol & q.on)) |=> ((q.ovl & $past(ol & q.on)) == $past(ol & q.on)))
		else $error("persisting overload not latched");

	a_therm_hold: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!ctl_clr |=> (q.therm & $past(q.therm)) == $past(q.therm))
		else $error("thermal latch dropped without clear command");

	a_therm_clear: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(ctl_clr && ot == '0) |=> q.therm == '0 ##0 q.ctl_pend)
		else $error("clear command left a thermal latch set");

	a_temp_wipe: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(q.ctl_frame && edges == EDGE_HOLD) |=> q.temp_err == '0)
		else $error("temperature error not wiped before third rise");

	a_temp_relatch: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(!wipe && |(ot & q.on)) |=>
		(q.temp_err & $past(ot & q.on)) == $past(ot & q.on))
		else $error("temperature error not latched outside the wipe");

	a_sense_off: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		q.sel == SEL_OFF |=> !sense_oe_o)
		else $error("sense output active while disabled");

	a_sense_fault: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(|(ot | ol)) |=> ((q.sense & $past(ot | ol)) == '0))
		else $error("sense stays on for a faulted channel");

	a_sense_gate: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(q.sense & ~$past(q.gate)) == '0 && $onehot0(q.sense))
		else $error("sense routed from an off or second channel");

	a_err_on_only: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		((q.ovl | q.temp_err) & ~$past(q.ovl | q.temp_err)
		& ~$past(q.on)) == '0)
		else $error("error flag set in off state");

	a_bypass_sel: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		($stable(q.sel) && q.sel < SEL_W'(NCH)) |=>
		q.bypass_monitor_result == $past(byp[q.sel]))
		else $error("bypass result not from selected channel");

	a_bypass_off: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		q.sel >= SEL_W'(NCH) |=> !q.bypass_monitor_result)
		else $error("bypass result set with no channel selected");

	a_soft_reset: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(fin && edges == EDGE_FRAME && cmd[CMD_WR] && cmd[HW_RST]
		&& cmd[CMD_A_HI:CMD_A_LO] == ADDR_HARDWARE_CONFIGURATION) |=>
		(q.sel == DCR_RST && q.led == WATCHDOG_LED_REGISTER_RST && q.on == OUT_RST
		&& !q.cfg3 && !q.pwm))
		else $error("soft reset left a register unchanged");
endmodule
`default_nettype wire

// ### verification/sdf_host.sv
// spi host model driving the diagnosis block: mode 0, msb first
// assumes sys_clk_i is the bench clock; sclk half period is 6 clocks
`timescale 1ns/1ps
`default_nettype none
module sdf_host (
	input wire logic sys_clk_i,
	input wire logic so_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic si_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b1;
	end
	// sclk stands still between frames; si flips once released
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(posedge sys_clk_i);
		cs_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--)
		begin
			si_o <= tx[i];
			repeat (6) @(posedge sys_clk_i);
			sclk_o <= 1'b1;
			rx[i] = so_i;
			repeat (6) @(posedge sys_clk_i);
			sclk_o <= 1'b0;
		end
		repeat (6) @(posedge sys_clk_i);
		cs_n_o <= 1'b1;
		si_o <= ~tx[0];
		// gap covers sync latency and command execution
		repeat (8) @(posedge sys_clk_i);
	endtask
endmodule
`default_nettype wire

// ### verification/test_switch_diagnosis_flags.sv
// self-checking bench for sdf_core via the spi host model
// assumes sdf_pkg constants; writes make the next frame a diagnosis
`timescale 1ns/1ps
`default_nettype none
module test_switch_diagnosis_flags;
	import sdf_pkg::*;
	logic sys_clk_i, nrst_i, cs_n, sclk, si, so, limp_home_state, oe, soe;
	logic [NCH-1:0] ot, ol, byp, gate, route;
	logic [NLED-1:0] led;
	logic [7:0] rx, v;
	int num_errors = 0;
	int n_tests = 0;
	sdf_core dut_u (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .spi_cs_n_i(cs_n),
		.spi_sclk_i(sclk), .spi_si_i(si), .limp_home_i(limp_home_state),
		.over_temp_i(ot), .overload_i(ol), .bypass_cmp_i(byp),
		.spi_so_o(so), .spi_so_oe_o(oe), .gate_on_o(gate),
		.sense_route_o(route), .sense_oe_o(soe), .led_mode_o(led)
	);
	sdf_host host_u (
		.sys_clk_i(sys_clk_i), .so_i(so), .cs_n_o(cs_n),
		.sclk_o(sclk), .si_o(si)
	);
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors=%0d checks=%0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [1:0] a, input logic [4:0] d);
		host_u.xfer({1'b1, a, d}, rx);
	endtask
	// a plain read leaves the following frame set to diagnosis
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		host_u.xfer({1'b0, a, 5'h10}, rx);
		host_u.xfer(8'h00, d);
	endtask
	task automatic diag(output logic [7:0] d);
		host_u.xfer(8'h00, d);
	endtask
	task automatic w4();
		repeat (4) @(posedge sys_clk_i);
	endtask
	initial
	begin
		#200000;
		num_errors++;
		end_sim();
	end
	initial
	begin
		nrst_i = 1'b0;
		limp_home_state = 1'b1;
		ot = 5'h00;
		ol = 5'h00;
		byp = 5'h00;
		repeat (8) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		w4();
		rd(ADDR_DCR, v);
		chk(v, {5'h00, DCR_RST});
		wr(ADDR_HARDWARE_CONFIGURATION, 5'h04);
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h10);
		wr(ADDR_OUT, 5'h1f);
		chk(8'(gate), 8'h1f);
		wr(ADDR_WATCHDOG_LED_REGISTER, 5'h05);
		chk(8'(led), 8'h05);
		ol <= 5'h02;
		w4();
		ol <= 5'h00;
		diag(v);
		chk(v, 8'h02);
		chk({7'h00, oe}, 8'h00);
		fork
			diag(v);
			begin
				repeat (20) @(posedge sys_clk_i);
				chk({7'h00, oe}, 8'h01);
			end
		join
		chk(v, 8'h00);
		ol <= 5'h04;
		w4();
		diag(v);
		chk(v, 8'h04);
		diag(v);
		chk(v, 8'h04);
		ol <= 5'h00;
		diag(v);
		chk(v, 8'h04);
		diag(v);
		chk(v, 8'h00);
		wr(ADDR_OUT, 5'h1d);
		ol <= 5'h02;
		w4();
		ol <= 5'h00;
		diag(v);
		chk(v, 8'h00);
		wr(ADDR_OUT, 5'h1f);
		ot <= 5'h01;
		w4();
		ot <= 5'h00;
		w4();
		chk(8'(gate), 8'h1e);
		diag(v);
		chk(v, 8'h01);
		wr(ADDR_HARDWARE_CONFIGURATION, 5'h00);
		chk(8'(gate), 8'h1e);
		wr(ADDR_HARDWARE_CONFIGURATION, 5'h01);
		chk(8'(gate), 8'h1f);
		diag(v);
		chk(v, 8'h01);
		diag(v);
		chk(v, 8'h00);
		byp <= 5'h15;
		for (int i = 0; i < NCH; i++)
		begin
			wr(ADDR_DCR, 5'(i));
			chk(8'(route), 8'(1 << i));
			chk({7'h00, soe}, 8'h01);
			rd(ADDR_HARDWARE_CONFIGURATION, v);
			chk(v & 8'hfe, {5'h02, byp[i], 2'h0});
		end
		wr(ADDR_DCR, 5'h02);
		ol <= 5'h04;
		w4();
		chk(8'(route), 8'h00);
		ol <= 5'h00;
		wr(ADDR_OUT, 5'h1b);
		chk(8'(route), 8'h00);
		byp <= 5'h0b;
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h10);
		byp <= 5'h04;
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h14);
		wr(ADDR_DCR, 5'h07);
		chk(8'(route), 8'h00);
		chk({7'h00, soe}, 8'h00);
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h10);
		wr(ADDR_HARDWARE_CONFIGURATION, 5'h0a);
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h1a);
		wr(ADDR_HARDWARE_CONFIGURATION, 5'h1b);
		rd(ADDR_HARDWARE_CONFIGURATION, v);
		chk(v & 8'hfe, 8'h10);
		rd(ADDR_OUT, v);
		chk(v, 8'h00);
		rd(ADDR_WATCHDOG_LED_REGISTER, v);
		chk(v, 8'h00);
		chk(8'(gate), 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
